// File: eam_merit_map.vh
// register offsets, field positions, reset values and the behaviour list for the merit register slice
// Behaviour
// - merit is min of (horiz - B)*A/127 and (vert - C)*(128-A)/127; B at 0x6c resets 0
// - vertical offset term C sits at 0x6d, 8 bits, resets 0, loadable from config memory
// - bit 7 of alternate_merit_enables selects the alternate merit for linear equalizer adaptation
// - bit 6 of alternate_merit_enables selects the alternate merit for feedback equalizer adaptation
// - look-beyond count in linear_eq_look_beyond bits 2:0, writable, resets to 3'b011
// - tap 1 result read-only: polarity bit 5, weight bits 4:0, writes ignored
// - taps 2 to 5 read-only: polarity bit 4, weight bits 3:0, own registers
// - weighting term A at 0x6b, 8 bits writable, resets to 8'h40
`ifndef EAM_MERIT_MAP_VH
`define EAM_MERIT_MAP_VH
`define EAM_OFS_TERM_A 8'h6b
`define EAM_OFS_TERM_B 8'h6c
`define EAM_OFS_TERM_C 8'h6d
`define EAM_OFS_ALT_EN 8'h6e
`define EAM_OFS_SPARE 8'h6f
`define EAM_OFS_LOOK 8'h70
`define EAM_OFS_TAP1 8'h71
`define EAM_OFS_TAP2 8'h72
`define EAM_OFS_TAP3 8'h73
`define EAM_OFS_TAP4 8'h74
`define EAM_OFS_TAP5 8'h75
`define EAM_RST_TERM_A 8'h40
`define EAM_RST_TERM_B 8'h00
`define EAM_RST_TERM_C 8'h00
`define EAM_RST_ALT_EN 2'h0
`define EAM_RST_LOOK 3'h3
`define EAM_BIT_ALT_LIN 7
`define EAM_BIT_ALT_FB 6
`define EAM_MERIT_DIV 8'h7f
`define EAM_MERIT_FULL 8'h80
`endif

// File: eam_merit_calc.v
// figure of merit arithmetic from eye openings and weighting terms
`timescale 1ns/100ps
`default_nettype none
`include "eam_merit_map.vh"
module eam_merit_calc (
   input wire core_clk_in,
   input wire sys_rst_in,
   input wire [7:0] horizontal_eye_opening_in,
   input wire [7:0] vertical_eye_opening_in,
   input wire [7:0] term_a_in,
   input wire [7:0] term_b_in,
   input wire [7:0] term_c_in,
   output reg [7:0] adaptation_merit_out
);
   reg [7:0] adaptation_merit_ff;
   reg [7:0] nxt_adaptation_merit;
   reg [8:0] h_diff;
   reg [8:0] v_diff;
   reg [16:0] h_prod;
   reg [16:0] v_prod;
   reg [16:0] h_term;
   reg [16:0] v_term;
   // opening minus offset, floored at zero so a large offset cannot wrap
   function [7:0] sat_sub;
      input [7:0] val;
      input [7:0] ofs;
      begin
         sat_sub = (val > ofs) ? (val - ofs) : 8'h00;
      end
   endfunction
   // merit = min of both weighted openings, each scaled by 1/127
   always @* begin
      h_diff = {1'b0, sat_sub(horizontal_eye_opening_in, term_b_in)};
      v_diff = {1'b0, sat_sub(vertical_eye_opening_in, term_c_in)};
      h_prod = h_diff * {1'b0, term_a_in};
      v_prod = v_diff * ({1'b0, `EAM_MERIT_FULL} - {1'b0, term_a_in});
      h_term = h_prod / {9'h000, `EAM_MERIT_DIV};
      v_term = v_prod / {9'h000, `EAM_MERIT_DIV};
      // a above 128 makes the vertical weight wrap; such a term counts as zero
      if (term_a_in > `EAM_MERIT_FULL) begin
         v_term = 17'h00000;
      end
      if (h_term < v_term) begin
         nxt_adaptation_merit = (h_term > 17'h000ff) ? 8'hff : h_term[7:0];
      end else begin
         nxt_adaptation_merit = (v_term > 17'h000ff) ? 8'hff : v_term[7:0];
      end
   end
   // registered result keeps the divider path off the engine's timing
   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         adaptation_merit_ff <= 8'h00;
      end else begin
         adaptation_merit_ff <= nxt_adaptation_merit;
      end
   end
   always @* begin
      adaptation_merit_out = adaptation_merit_ff;
   end
endmodule
`default_nettype wire

// File: eam_merit_regs.v
// per-channel merit weighting, alternate merit enables, look-beyond count and tap results
`timescale 1ns/100ps
`default_nettype none
`include "eam_merit_map.vh"
module eam_merit_regs (
   input wire core_clk_in,
   input wire sys_rst_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   output wire reg_hit_out,
   input wire cfg_load_in,
   input wire [7:0] cfg_addr_in,
   input wire [7:0] cfg_data_in,
   input wire [7:0] horizontal_eye_opening_in,
   input wire [7:0] vertical_eye_opening_in,
   input wire linear_equalizer_adapting_in,
   input wire feedback_equalizer_adapting_in,
   input wire tap_update_in,
   input wire [5:0] tap1_result_in,
   input wire [19:0] taps2to5_result_in,
   output wire [7:0] adaptation_merit_out,
   output wire use_alt_merit_out,
   output wire [2:0] look_beyond_count_out,
   output wire [7:0] term_a_out,
   output wire [7:0] term_b_out,
   output wire [7:0] term_c_out
);
   reg [7:0] term_a_ff;
   reg [7:0] term_b_ff;
   reg [7:0] term_c_ff;
   reg [1:0] alt_en_ff;
   reg [2:0] look_ff;
   reg [5:0] tap1_ff;
   reg [19:0] taps_ff;
   reg [7:0] rdata_ff;
   reg [7:0] nxt_rdata;
   reg hit;
   wire wr_a;
   wire wr_b;
   wire wr_c;
   wire wr_alt;
   wire wr_look;
   // config memory load and host write share one write path; host wins a tie
   function wr_sel;
      input [7:0] ofs;
      begin
         wr_sel = (reg_wr_in && reg_addr_in == ofs) || (!reg_wr_in && cfg_load_in && cfg_addr_in == ofs);
      end
   endfunction
   wire [7:0] wsrc = reg_wr_in ? reg_wdata_in : cfg_data_in;
   assign wr_a = wr_sel(`EAM_OFS_TERM_A);
   assign wr_b = wr_sel(`EAM_OFS_TERM_B);
   assign wr_c = wr_sel(`EAM_OFS_TERM_C);
   assign wr_alt = wr_sel(`EAM_OFS_ALT_EN);
   // look-beyond is not held in config memory, so host only
   assign wr_look = reg_wr_in && reg_addr_in == `EAM_OFS_LOOK;
   // writable fields; reserved bits are not stored at all
   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         term_a_ff <= `EAM_RST_TERM_A;
         term_b_ff <= `EAM_RST_TERM_B;
         term_c_ff <= `EAM_RST_TERM_C;
         alt_en_ff <= `EAM_RST_ALT_EN;
         look_ff <= `EAM_RST_LOOK;
      end else begin
         if (wr_a) begin
            term_a_ff <= wsrc;
         end
         if (wr_b) begin
            term_b_ff <= wsrc;
         end
         if (wr_c) begin
            term_c_ff <= wsrc;
         end
         if (wr_alt) begin
            alt_en_ff <= {wsrc[`EAM_BIT_ALT_LIN], wsrc[`EAM_BIT_ALT_FB]};
         end
         if (wr_look) begin
            look_ff <= reg_wdata_in[2:0];
         end
      end
   end
   // tap results come only from the adaptation engine; bus writes never reach them
   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tap1_ff <= 6'h00;
         taps_ff <= 20'h00000;
      end else if (tap_update_in) begin
         tap1_ff <= tap1_result_in;
         taps_ff <= taps2to5_result_in;
      end
   end
   // read decode; spare and reserved bits read as zero, their reset value
   always @* begin
      nxt_rdata = 8'h00;
      hit = 1'b1;
      case (reg_addr_in)
         `EAM_OFS_TERM_A: nxt_rdata = term_a_ff;
         `EAM_OFS_TERM_B: nxt_rdata = term_b_ff;
         `EAM_OFS_TERM_C: nxt_rdata = term_c_ff;
         `EAM_OFS_ALT_EN: nxt_rdata = {alt_en_ff, 6'h00};
         `EAM_OFS_SPARE: nxt_rdata = 8'h00;
         `EAM_OFS_LOOK: nxt_rdata = {5'h00, look_ff};
         `EAM_OFS_TAP1: nxt_rdata = {2'h0, tap1_ff};
         `EAM_OFS_TAP2: nxt_rdata = {3'h0, taps_ff[4:0]};
         `EAM_OFS_TAP3: nxt_rdata = {3'h0, taps_ff[9:5]};
         `EAM_OFS_TAP4: nxt_rdata = {3'h0, taps_ff[14:10]};
         `EAM_OFS_TAP5: nxt_rdata = {3'h0, taps_ff[19:15]};
         default: hit = 1'b0;
      endcase
   end
   // read data registered one cycle after the strobe
   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_ff <= nxt_rdata;
      end
   end
   always @* begin
      reg_rdata_out = rdata_ff;
   end
   assign reg_hit_out = hit;
   // alternate merit chosen per equalizer stage currently adapting
   assign use_alt_merit_out = (linear_equalizer_adapting_in && alt_en_ff[1])
                            || (feedback_equalizer_adapting_in && alt_en_ff[0]);
   assign look_beyond_count_out = look_ff;
   assign term_a_out = term_a_ff;
   assign term_b_out = term_b_ff;
   assign term_c_out = term_c_ff;
   eam_merit_calc u_calc (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .horizontal_eye_opening_in(horizontal_eye_opening_in),
      .vertical_eye_opening_in(vertical_eye_opening_in),
      .term_a_in(term_a_ff),
      .term_b_in(term_b_ff),
      .term_c_in(term_c_ff),
      .adaptation_merit_out(adaptation_merit_out)
   );
endmodule
`default_nettype wire

// File: eam_merit_regs_asserts.sv
// port checks for the merit register slice
`timescale 1ns/100ps
`default_nettype none
module eam_merit_regs_asserts (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_hit_out,
   input wire logic cfg_load_in,
   input wire logic linear_equalizer_adapting_in,
   input wire logic feedback_equalizer_adapting_in,
   input wire logic use_alt_merit_out,
   input wire logic [2:0] look_beyond_count_out,
   input wire logic [7:0] term_a_out,
   input wire logic [7:0] term_b_out,
   input wire logic [7:0] term_c_out
);
   // single domain, so clock and reset are given once
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // short aliases keep each check on one line
   wire w = reg_wr_in;
   wire [7:0] a = reg_addr_in;
   wire [7:0] d = reg_wdata_in;
   wire wr_alt = w && a == 8'h6e;
   wire lin_only = linear_equalizer_adapting_in && !feedback_equalizer_adapting_in;
   wire fb_only = feedback_equalizer_adapting_in && !linear_equalizer_adapting_in;
   chk_term_a_load: assert property (w && a == 8'h6b |=> term_a_out == $past(d)) else $error("term a lost");
   chk_term_a_hold: assert property (!w && !cfg_load_in |=> $stable(term_a_out)) else $error("term a moved");
   chk_term_b_load: assert property (w && a == 8'h6c |=> term_b_out == $past(d)) else $error("term b lost");
   chk_term_c_load: assert property (w && a == 8'h6d |=> term_c_out == $past(d)) else $error("term c lost");
   chk_look_load: assert property (w && a == 8'h70 |=> look_beyond_count_out == $past(d[2:0])) else $error("look");
   chk_alt_linear: assert property (wr_alt ##1 lin_only |-> use_alt_merit_out == $past(d[7])) else $error("alt lin");
   chk_alt_feedback: assert property (wr_alt ##1 fb_only |-> use_alt_merit_out == $past(d[6])) else $error("alt fb");
   chk_unmapped_zero: assert property (reg_rd_in && !reg_hit_out |=> reg_rdata_out == 8'h00) else $error("rd");
   chk_hit_range: assert property (reg_hit_out == (a >= 8'h6b && a <= 8'h75)) else $error("hit range");
   cover property (wr_alt ##1 lin_only);
   cover property (wr_alt ##1 fb_only);
   cover property (reg_rd_in && !reg_hit_out);
endmodule
bind eam_merit_regs eam_merit_regs_asserts u_chk (.*);
`default_nettype wire

// File: eam_mgmt_host.sv
// host model issuing one-cycle write and read strobes
// one host per slice on its own bus, so the device address is never shared
`timescale 1ns/100ps
`default_nettype none
module eam_mgmt_host (
   input wire logic core_clk_in,
   input wire logic [7:0] rdata_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out
);
   // idle bus from time zero so no strobe is ever unknown
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
   end
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge core_clk_in);
      reg_wr_out <= 1'b1;
      reg_addr_out <= ad;
      reg_wdata_out <= dt;
      @(posedge core_clk_in);
      reg_wr_out <= 1'b0;
   endtask
   // data sampled a full cycle late, the slice holds it until the next read
   task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
      @(posedge core_clk_in);
      reg_rd_out <= 1'b1;
      reg_addr_out <= ad;
      @(posedge core_clk_in);
      reg_rd_out <= 1'b0;
      @(posedge core_clk_in);
      #1 dt = rdata_in;
   endtask
endmodule
`default_nettype wire

// File: eam_merit_regs_tb.sv
// testbench for the merit register slice
`timescale 1ns/100ps
`default_nettype none
module eam_merit_regs_tb;
   logic core_clk_in = 1'b0, sys_rst_in = 1'b1, cfg_load_in = 1'b0, tap_update_in = 1'b0, reg_hit_out;
   logic linear_equalizer_adapting_in = 1'b1, feedback_equalizer_adapting_in = 1'b0, use_alt_merit_out;
   logic reg_wr_in, reg_rd_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, adaptation_merit_out, term_a_out, term_b_out, term_c_out, v;
   logic [7:0] cfg_addr_in = 8'h00, cfg_data_in = 8'h00, horizontal_eye_opening_in = 8'h00;
   logic [7:0] vertical_eye_opening_in = 8'h00;
   logic [5:0] tap1_result_in = 6'h00;
   logic [19:0] taps2to5_result_in = 20'h00000;
   logic [2:0] look_beyond_count_out;
   int failures = 0, n_tests = 0;
   // rows: horizontal, vertical, term a, term b, term c, expected merit
   logic [47:0] rows [4] = '{48'h808040000040, 48'h50ff7f100002, 48'hff9020001040, 48'h108040200000};
   logic [7:0] rst_vals [6] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
   eam_merit_regs u_dut (.*);
   eam_mgmt_host u_host (.core_clk_in, .rdata_in(reg_rdata_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
      .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
   always #5 core_clk_in = ~core_clk_in;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      u_host.rd(ad, v);
      chk(v, exp);
   endtask
   // one stage adapting at a time, flag read a cycle later
   task automatic alt_case(input logic l, input logic f, input logic [7:0] exp);
      @(posedge core_clk_in);
      linear_equalizer_adapting_in <= l;
      feedback_equalizer_adapting_in <= f;
      @(posedge core_clk_in);
      #1 chk({7'h0, use_alt_merit_out}, exp);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // cut a hang short well beyond the expected run
   initial begin
      #100000;
      failures++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_chk(8'h6b + 8'(i), rst_vals[i]);
      end
      $display("reset values done");
      foreach (rows[i]) begin
         u_host.wr(8'h6b, rows[i][31:24]);
         u_host.wr(8'h6c, rows[i][23:16]);
         u_host.wr(8'h6d, rows[i][15:8]);
         horizontal_eye_opening_in <= rows[i][47:40];
         vertical_eye_opening_in <= rows[i][39:32];
         repeat (3) @(posedge core_clk_in);
         #1 chk(adaptation_merit_out, rows[i][7:0]);
      end
      $display("merit rows done");
      @(posedge core_clk_in);
      tap1_result_in <= 6'h2a;
      taps2to5_result_in <= 20'hfc1e1;
      tap_update_in <= 1'b1;
      @(posedge core_clk_in);
      tap_update_in <= 1'b0;
      u_host.wr(8'h71, 8'hff);
      u_host.wr(8'h72, 8'hff);
      u_host.wr(8'h70, 8'hff);
      rd_chk(8'h71, 8'h2a);
      rd_chk(8'h72, 8'h01);
      rd_chk(8'h75, 8'h1f);
      rd_chk(8'h70, 8'h07);
      rd_chk(8'h80, 8'h00);
      $display("taps and reserved done");
      u_host.wr(8'h6e, 8'h80);
      alt_case(1'b1, 1'b0, 8'h01);
      alt_case(1'b0, 1'b1, 8'h00);
      u_host.wr(8'h6e, 8'h40);
      alt_case(1'b0, 1'b1, 8'h01);
      alt_case(1'b1, 1'b0, 8'h00);
      @(posedge core_clk_in);
      cfg_load_in <= 1'b1;
      cfg_addr_in <= 8'h6d;
      cfg_data_in <= 8'h33;
      @(posedge core_clk_in);
      cfg_load_in <= 1'b0;
      #1 chk(term_c_out, 8'h33);
      u_host.wr(8'h6b, 8'h11);
      @(posedge core_clk_in);
      #1 chk(term_a_out, 8'h11);
      // mid-run reset: fields must fall back even after non-default values
      @(posedge core_clk_in);
      sys_rst_in <= 1'b1;
      @(posedge core_clk_in);
      #1 chk(term_c_out, 8'h00);
      chk(term_a_out, 8'h40);
      @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      rd_chk(8'h6b, 8'h40);
      $display("alternate, load and reset done");
      print_verdict;
   end
endmodule
`default_nettype wire
